//--- hdl/rtc_alarm_pkg.sv
package rtc_alarm_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_ALARM_MINUTE = 8'h08;
  localparam logic [7:0] IDX_ALARM_HOUR = 8'h09;
  localparam logic [7:0] IDX_ALARM_WEEK_OR_DAY = 8'h0A;
  localparam logic [7:0] IDX_PRESET_LO = 8'h0B;
  localparam logic [7:0] IDX_PRESET_HI = 8'h0C;
  localparam logic [7:0] IDX_EXTENSION_CONTROL = 8'h0D;
  localparam logic [7:0] IDX_EVENT_FLAGS = 8'h0E;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0F;

  // ==========================================================
  // Field positions
  localparam int CMP_DIS_BIT = 7;
  localparam int EXT_TE_BIT = 4;
  localparam int EXT_WDS_BIT = 3;
  localparam int FLG_TF_BIT = 4;
  localparam int FLG_AF_BIT = 3;
  localparam int CTL_TIE_BIT = 4;
  localparam int CTL_AIE_BIT = 3;
  localparam int CTL_TSTP_BIT = 2;
  localparam int CTL_STOP_BIT = 1;

  // ==========================================================
  // Reset values and encodings
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  localparam logic [2:0] SRC_4096HZ = 3'h0;
  localparam logic [2:0] SRC_64HZ = 3'h1;
  localparam logic [2:0] SRC_1HZ = 3'h2;
  localparam logic [2:0] SRC_1MIN = 3'h3;
  localparam logic [2:0] SRC_1HOUR = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ALARM_LATENCY_US = 1460;
  localparam int ALARM_LATENCY_CYCLES = (ALARM_LATENCY_US * 1000) / CLK_PERIOD_PS;

endpackage : rtc_alarm_pkg

//--- hdl/countdown_unit.sv
`timescale 1ns/1ps
module countdown_unit
  import rtc_alarm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic pause,
  input wire logic tick,
  input wire logic [15:0] preset,
  output logic [15:0] count_q,
  output logic event_q
);

  logic enable_q;
  logic start;
  logic step;
  logic at_one;
  logic [15:0] count_d;

  // ==========================================================
  // Count control
  assign start = enable & ~enable_q;
  assign step = enable & tick & ~pause & ~start;
  assign at_one = (count_q == 16'h0001);

  // A preset of zero reloads zero forever, so no event ever fires
  assign count_d = (!enable || start) ? preset :
                   !step ? count_q :
                   (at_one || count_q == 16'h0000) ? preset :
                   count_q - 16'h0001;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_q <= 1'b0;
      count_q <= PRESET_RESET;
      event_q <= 1'b0;
    end else begin
      enable_q <= enable;
      count_q <= count_d;
      event_q <= step & at_one;
    end
  end

  AST_RELOAD: assert property (@(posedge clk) disable iff (rst)
    step && at_one && $stable(preset) |=> event_q && count_q == preset)
    else $error("countdown did not reload after reaching zero");

  AST_START: assert property (@(posedge clk) disable iff (rst)
    $rose(enable) |-> ##1 count_q == $past(preset))
    else $error("countdown did not start from preset");

  AST_ZERO_PRESET: assert property (@(posedge clk) disable iff (rst)
    enable && preset == 16'h0000 && $past(preset) == 16'h0000 |-> !event_q ##1 !event_q)
    else $error("zero preset produced a countdown event");

endmodule : countdown_unit

//--- hdl/alarm_compare.sv
`timescale 1ns/1ps
module alarm_compare
  import rtc_alarm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] alarm_minute,
  input wire logic [7:0] alarm_hour,
  input wire logic [7:0] alarm_week_or_day,
  input wire logic week_day_select,
  input wire logic clock_stop,
  input wire logic time_advance,
  input wire logic [7:0] cal_minute,
  input wire logic [7:0] cal_hour,
  input wire logic [6:0] cal_weekday,
  input wire logic [7:0] cal_day,
  output logic event_q
);

  logic min_ok;
  logic hour_ok;
  logic day_ok;
  logic all_ok;

  // ==========================================================
  // Field comparison, BCD as stored
  assign min_ok = alarm_minute[CMP_DIS_BIT] |
                  (alarm_minute[6:0] == cal_minute[6:0]);
  assign hour_ok = alarm_hour[CMP_DIS_BIT] |
                   (alarm_hour[5:0] == cal_hour[5:0]);
  assign day_ok = alarm_week_or_day[CMP_DIS_BIT] |
                  (week_day_select ?
                   (alarm_week_or_day[5:0] == cal_day[5:0]) :
                   |(alarm_week_or_day[6:0] & cal_weekday));
  // Comparison runs whatever the interrupt enable holds
  assign all_ok = min_ok & hour_ok & day_ok;

  // Only an advance of the counters can fire, never a register write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_q <= 1'b0;
    end else begin
      event_q <= time_advance & all_ok & ~clock_stop;
    end
  end

  AST_STOP_BLOCKS: assert property (@(posedge clk) disable iff (rst)
    clock_stop |=> !event_q)
    else $error("alarm event while clock stopped");

  AST_EVERY_MINUTE: assert property (@(posedge clk) disable iff (rst)
    time_advance && !clock_stop && alarm_minute[CMP_DIS_BIT] && alarm_hour[CMP_DIS_BIT]
    && alarm_week_or_day[CMP_DIS_BIT] |=> event_q)
    else $error("all fields disabled but no alarm");

  AST_NO_ADVANCE: assert property (@(posedge clk) disable iff (rst)
    !time_advance |=> !event_q)
    else $error("alarm raised without counter advance");

endmodule : alarm_compare

//--- hdl/rtc_irq_top.sv
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
// Function
// - Countdown interval is preset times the selected source tick period.
// - Step from one to zero raises an event, reloads preset, repeats.
// - Enable rising from zero always restarts countdown from the preset.
// - Alarm match sets the alarm flag and pulls the interrupt low if enabled.
// - Alarm flag and interrupt update within 1.46 ms of the match.
// - Alarm interrupt stays low until software cancels it; no auto release.
// - While the clock stop bit is one, no alarm events occur.
// - Week-or-day register holds weekday mask or day; weekday bits may multi-match.
// - A field whose compare-disable bit is one is left out of comparison.
// - With all three compares disabled, an alarm fires every minute.
// - Alarm fires only when counters advance into a match, not on writes.
// - Select zero targets weekday, select one targets day of month.
// - Comparison continues when alarm registers serve as plain storage.
// - Alarm flag holds until written zero; writing one does nothing.
// - Alarm interrupt enable gates only the output; flag needs its own clear.
// - Countdown flag sets per event and holds until cleared to zero.
module rtc_irq_top
  import rtc_alarm_pkg::*;
#(
  parameter int ALARM_MAX_CYCLES = ALARM_LATENCY_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tick_4096hz,
  input wire logic tick_64hz,
  input wire logic tick_1hz,
  input wire logic tick_1min,
  input wire logic tick_1hour,
  input wire logic time_advance,
  input wire logic [7:0] cal_minute,
  input wire logic [7:0] cal_hour,
  input wire logic [6:0] cal_weekday,
  input wire logic [7:0] cal_day,
  input wire logic irq_n_i,
  output logic irq_n_o,
  output logic irq_n_oe
);

  // ==========================================================
  // Register state
  logic [7:0] alarm_minute_q;
  logic [7:0] alarm_hour_q;
  logic [7:0] alarm_week_or_day_q;
  logic [15:0] preset_q;
  logic [7:0] extension_control_q;
  logic [4:1] interrupt_control_q;
  logic alarm_event_flag_q;
  logic countdown_event_flag_q;
  logic alarm_event_flag_d;
  logic countdown_event_flag_d;
  logic irq_n_oe_d;

  logic countdown_enable;
  logic week_day_select;
  logic [2:0] countdown_source_sel;
  logic countdown_irq_enable;
  logic alarm_irq_enable;
  logic countdown_pause;
  logic clock_stop;

  assign countdown_enable = extension_control_q[EXT_TE_BIT];
  assign week_day_select = extension_control_q[EXT_WDS_BIT];
  assign countdown_source_sel = extension_control_q[2:0];
  assign countdown_irq_enable = interrupt_control_q[CTL_TIE_BIT];
  assign alarm_irq_enable = interrupt_control_q[CTL_AIE_BIT];
  assign countdown_pause = interrupt_control_q[CTL_TSTP_BIT];
  assign clock_stop = interrupt_control_q[CTL_STOP_BIT];

  // ==========================================================
  // Pin input: the line level is not used by this block
  logic irq_pin_meta_q;
  logic irq_pin_sync_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_pin_meta_q <= 1'b1;
      irq_pin_sync_q <= 1'b1;
    end else begin
      irq_pin_meta_q <= irq_n_i;
      irq_pin_sync_q <= irq_pin_meta_q;
    end
  end

  // ==========================================================
  // Write channel
  logic aw_hold_q;
  logic [7:0] aw_addr_q;
  logic w_hold_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic aw_hold_d;
  logic w_hold_d;
  logic bvalid_d;
  logic [7:0] wr_idx;
  logic wr_mapped;
  logic wr_en;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign aw_hold_d = (aw_hold_q & ~do_write) | aw_take;
  assign w_hold_d = (w_hold_q & ~do_write) | w_take;
  assign bvalid_d = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign wr_idx = {2'b00, aw_addr_q[7:2]};
  assign wr_mapped = (aw_addr_q[1:0] == 2'b00) &
                     (wr_idx >= IDX_ALARM_MINUTE) & (wr_idx <= IDX_INTERRUPT_CONTROL);
  // Only byte lane zero carries register data
  assign wr_en = do_write & wr_mapped & w_lane0_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      s_axi_awready <= ~aw_hold_d;
      s_axi_wready <= ~w_hold_d;
      s_axi_bvalid <= bvalid_d;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Register writes
  logic wr_flags;

  assign wr_flags = wr_en & (wr_idx == IDX_EVENT_FLAGS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_minute_q <= REG_RESET;
      alarm_hour_q <= REG_RESET;
      alarm_week_or_day_q <= REG_RESET;
      preset_q <= PRESET_RESET;
      extension_control_q <= REG_RESET;
      interrupt_control_q <= 4'h0;
    end else if (wr_en) begin
      case (wr_idx)
        IDX_ALARM_MINUTE: alarm_minute_q <= w_data_q;
        IDX_ALARM_HOUR: alarm_hour_q <= w_data_q;
        IDX_ALARM_WEEK_OR_DAY: alarm_week_or_day_q <= w_data_q;
        IDX_PRESET_LO: preset_q[7:0] <= w_data_q;
        IDX_PRESET_HI: preset_q[15:8] <= w_data_q;
        IDX_EXTENSION_CONTROL: extension_control_q <= w_data_q;
        IDX_INTERRUPT_CONTROL: interrupt_control_q <= w_data_q[4:1];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Countdown and alarm engines
  logic src_tick;
  logic gated_tick;
  logic [15:0] countdown_value;
  logic countdown_event;
  logic alarm_event;

  assign src_tick = (countdown_source_sel == SRC_4096HZ) ? tick_4096hz :
                    (countdown_source_sel == SRC_64HZ) ? tick_64hz :
                    (countdown_source_sel == SRC_1HZ) ? tick_1hz :
                    (countdown_source_sel == SRC_1MIN) ? tick_1min :
                    (countdown_source_sel == SRC_1HOUR) ? tick_1hour : 1'b0;
  // Calendar-derived sources freeze with the clock
  assign gated_tick = src_tick & ~(clock_stop & (countdown_source_sel >= SRC_1HZ));

  countdown_unit u_countdown (
    .clk(clk),
    .rst(rst),
    .enable(countdown_enable),
    .pause(countdown_pause),
    .tick(gated_tick),
    .preset(preset_q),
    .count_q(countdown_value),
    .event_q(countdown_event)
  );

  alarm_compare u_alarm (
    .clk(clk),
    .rst(rst),
    .alarm_minute(alarm_minute_q),
    .alarm_hour(alarm_hour_q),
    .alarm_week_or_day(alarm_week_or_day_q),
    .week_day_select(week_day_select),
    .clock_stop(clock_stop),
    .time_advance(time_advance),
    .cal_minute(cal_minute),
    .cal_hour(cal_hour),
    .cal_weekday(cal_weekday),
    .cal_day(cal_day),
    .event_q(alarm_event)
  );

  // ==========================================================
  // Event flags and interrupt pin
  // A new event beats a clear written in the same cycle
  assign alarm_event_flag_d = alarm_event |
                              (alarm_event_flag_q &
                               ~(wr_flags & ~w_data_q[FLG_AF_BIT]));
  assign countdown_event_flag_d = countdown_event |
                                  (countdown_event_flag_q &
                                   ~(wr_flags & ~w_data_q[FLG_TF_BIT]));
  // Level output: no release timer, clearing the flag or its enable releases it
  assign irq_n_oe_d = (alarm_event_flag_d & alarm_irq_enable) |
                      (countdown_event_flag_d & countdown_irq_enable);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_event_flag_q <= 1'b0;
      countdown_event_flag_q <= 1'b0;
      irq_n_oe <= 1'b0;
      irq_n_o <= 1'b0;
    end else begin
      alarm_event_flag_q <= alarm_event_flag_d;
      countdown_event_flag_q <= countdown_event_flag_d;
      irq_n_oe <= irq_n_oe_d;
      irq_n_o <= 1'b0;
    end
  end

  // ==========================================================
  // Read channel
  logic ar_take;
  logic rvalid_d;
  logic [7:0] rd_idx;
  logic rd_mapped;
  logic [7:0] rd_byte;
  logic [7:0] flags_view;
  logic [15:0] timer_view;

  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
  assign rd_idx = {2'b00, s_axi_araddr[7:2]};
  assign rd_mapped = (s_axi_araddr[1:0] == 2'b00) &
                     (rd_idx >= IDX_ALARM_MINUTE) & (rd_idx <= IDX_INTERRUPT_CONTROL);
  assign flags_view = {3'b000, countdown_event_flag_q, alarm_event_flag_q, 3'b000};
  // Running count while enabled, otherwise the preset
  assign timer_view = countdown_enable ? countdown_value : preset_q;
  assign rd_byte = (rd_idx == IDX_ALARM_MINUTE) ? alarm_minute_q :
                   (rd_idx == IDX_ALARM_HOUR) ? alarm_hour_q :
                   (rd_idx == IDX_ALARM_WEEK_OR_DAY) ? alarm_week_or_day_q :
                   (rd_idx == IDX_PRESET_LO) ? timer_view[7:0] :
                   (rd_idx == IDX_PRESET_HI) ? timer_view[15:8] :
                   (rd_idx == IDX_EXTENSION_CONTROL) ? extension_control_q :
                   (rd_idx == IDX_EVENT_FLAGS) ? flags_view :
                   (rd_idx == IDX_INTERRUPT_CONTROL) ? {3'b000, interrupt_control_q, 1'b0} :
                   8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Checks
  logic [31:0] latency_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latency_q <= 32'h00000000;
    end else if (alarm_event || (latency_q != 32'h00000000 && !alarm_event_flag_q)) begin
      latency_q <= latency_q + 32'h00000001;
    end else begin
      latency_q <= 32'h00000000;
    end
  end

  AST_ALARM_LATENCY: assert property (@(posedge clk) disable iff (rst)
    latency_q <= 32'(ALARM_MAX_CYCLES))
    else $error("alarm flag late after match");

  AST_ALARM_SETS_PIN: assert property (@(posedge clk) disable iff (rst)
    alarm_event && alarm_irq_enable |=> alarm_event_flag_q && irq_n_oe)
    else $error("alarm match did not drive interrupt");

  AST_FLAG_HOLDS: assert property (@(posedge clk) disable iff (rst)
    alarm_event_flag_q && !wr_flags |=> alarm_event_flag_q)
    else $error("alarm flag dropped without clear");

  AST_PIN_HOLDS: assert property (@(posedge clk) disable iff (rst)
    irq_n_oe && alarm_event_flag_q && alarm_irq_enable && !wr_en |=> irq_n_oe)
    else $error("interrupt released without cancel");

  AST_ENABLE_GATES: assert property (@(posedge clk) disable iff (rst)
    !alarm_irq_enable && !countdown_irq_enable && $stable(interrupt_control_q) |=> !irq_n_oe)
    else $error("interrupt driven while all enables clear");

  AST_TF_SET: assert property (@(posedge clk) disable iff (rst)
    countdown_event |=> countdown_event_flag_q)
    else $error("countdown event lost");

endmodule : rtc_irq_top

//--- verification/axi_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Register host: one write or read at a time
module axi_host_model (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // Released payloads are inverted so a slave never sees stale data
  task automatic write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~{24'h000000, d};
      end
    end
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    // One idle edge keeps a following call from driving the same signals in this step
    @(posedge clk);
  endtask : write

  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : read
endmodule : axi_host_model

//--- verification/rtc_countdown_and_alarm_irq_bench.sv
`timescale 1ns/1ps
module rtc_countdown_and_alarm_irq_bench;
  import rtc_alarm_pkg::*;
  // ==========================================================
  // Wiring
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr, araddr, cal_m, cal_h, cal_d;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [4:0] tk;
  logic [6:0] cal_w;
  logic adv_p, irq_n_o, irq_n_oe;
  int n_mismatch = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;

  axi_host_model host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // Short bound keeps the in-design latency check tight
  rtc_irq_top #(.ALARM_MAX_CYCLES(4)) DUT (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tick_4096hz(tk[0]), .tick_64hz(tk[1]), .tick_1hz(tk[2]), .tick_1min(tk[3]),
    .tick_1hour(tk[4]), .time_advance(adv_p), .cal_minute(cal_m), .cal_hour(cal_h),
    .cal_weekday(cal_w), .cal_day(cal_d), .irq_n_i(irq_n_oe ? irq_n_o : 1'b1),
    .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));

  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    host.write({idx[5:0], 2'b00}, d, r);
    chk("bresp", 8'h00, {6'h00, r});
  endtask : wr

  task automatic rc(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    host.read({idx[5:0], 2'b00}, d, r);
    chk("rresp", 8'h00, {6'h00, r});
    chk(what, exp, d[7:0]);
  endtask : rc

  task automatic tp(input int s);
    tk[s] <= 1'b1;
    @(posedge clk);
    tk <= 5'h00;
    repeat (3) @(posedge clk);
  endtask : tp

  task automatic adv(input logic [7:0] m, input logic [7:0] h, input logic [6:0] w,
                     input logic [7:0] d, input logic [7:0] exp, input bit keep);
    cal_m <= m;
    cal_h <= h;
    cal_w <= w;
    cal_d <= d;
    adv_p <= 1'b1;
    @(posedge clk);
    adv_p <= 1'b0;
    repeat (3) @(posedge clk);
    rc("alarm flag", IDX_EVENT_FLAGS, exp);
    if (!keep) wr(IDX_EVENT_FLAGS, 8'h00);
  endtask : adv

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 8; i < 16; i++) rc("reset value", i[7:0], REG_RESET);
    wr(IDX_ALARM_MINUTE, 8'h5A);
    rc("alarm storage", IDX_ALARM_MINUTE, 8'h5A);
    host.write(8'h40, 8'h11, r);
    chk("unmapped bresp", {6'h00, RESP_SLVERR}, {6'h00, r});
    host.read(8'h40, d, r);
    chk("unmapped rresp", {6'h00, RESP_SLVERR}, {6'h00, r});
    chk("unmapped rdata", 8'h00, d[7:0]);
    $display("test regs done");
  endtask : t_regs

  task automatic t_count;
    wr(IDX_INTERRUPT_CONTROL, 8'h10);
    for (int s = 0; s < 5; s++) begin
      wr(IDX_PRESET_LO, 8'h02);
      wr(IDX_PRESET_HI, 8'h00);
      wr(IDX_EXTENSION_CONTROL, {5'h02, s[2:0]});
      tp(s);
      rc("early flag", IDX_EVENT_FLAGS, 8'h00);
      tp(s);
      rc("count flag", IDX_EVENT_FLAGS, 8'h10);
      chk("irq count", 8'h01, {7'h00, irq_n_oe});
      wr(IDX_EVENT_FLAGS, 8'h10);
      rc("flag hold", IDX_EVENT_FLAGS, 8'h10);
      wr(IDX_EVENT_FLAGS, 8'h00);
      rc("flag clear", IDX_EVENT_FLAGS, 8'h00);
      chk("irq release", 8'h00, {7'h00, irq_n_oe});
      tp(s);
      tp(s);
      rc("reload flag", IDX_EVENT_FLAGS, 8'h10);
      wr(IDX_EXTENSION_CONTROL, 8'h00);
      wr(IDX_EVENT_FLAGS, 8'h00);
    end
    wr(IDX_INTERRUPT_CONTROL, 8'h00);
    $display("test countdown done");
  endtask : t_count

  task automatic t_restart;
    wr(IDX_PRESET_LO, 8'h03);
    wr(IDX_EXTENSION_CONTROL, 8'h10);
    tp(0);
    tp(0);
    rc("running count", IDX_PRESET_LO, 8'h01);
    wr(IDX_EXTENSION_CONTROL, 8'h00);
    wr(IDX_EXTENSION_CONTROL, 8'h10);
    tp(0);
    rc("restart count", IDX_PRESET_LO, 8'h02);
    wr(IDX_INTERRUPT_CONTROL, 8'h04);
    tp(0);
    rc("paused count", IDX_PRESET_LO, 8'h02);
    wr(IDX_INTERRUPT_CONTROL, 8'h00);
    wr(IDX_EXTENSION_CONTROL, 8'h00);
    wr(IDX_PRESET_LO, 8'h00);
    wr(IDX_EXTENSION_CONTROL, 8'h10);
    tp(0);
    tp(0);
    rc("zero preset", IDX_EVENT_FLAGS, 8'h00);
    wr(IDX_EXTENSION_CONTROL, 8'h00);
    $display("test restart done");
  endtask : t_restart

  task automatic t_alarm;
    wr(IDX_INTERRUPT_CONTROL, 8'h00);
    wr(IDX_ALARM_MINUTE, 8'h30);
    wr(IDX_ALARM_HOUR, 8'h07);
    wr(IDX_ALARM_WEEK_OR_DAY, 8'h80);
    wr(IDX_INTERRUPT_CONTROL, 8'h08);
    cal_m <= 8'h30;
    cal_h <= 8'h07;
    repeat (4) @(posedge clk);
    rc("no write alarm", IDX_EVENT_FLAGS, 8'h00);
    adv(8'h29, 8'h07, 7'h01, 8'h01, 8'h00, 1'b0);
    adv(8'h30, 8'h07, 7'h01, 8'h01, 8'h08, 1'b1);
    chk("irq alarm", 8'h01, {7'h00, irq_n_oe});
    chk("irq drive level", 8'h00, {7'h00, irq_n_o});
    repeat (60) @(posedge clk);
    chk("irq held", 8'h01, {7'h00, irq_n_oe});
    wr(IDX_EVENT_FLAGS, 8'h08);
    rc("write one", IDX_EVENT_FLAGS, 8'h08);
    wr(IDX_INTERRUPT_CONTROL, 8'h00);
    chk("irq gated", 8'h00, {7'h00, irq_n_oe});
    rc("flag kept", IDX_EVENT_FLAGS, 8'h08);
    wr(IDX_EVENT_FLAGS, 8'h00);
    rc("flag cleared", IDX_EVENT_FLAGS, 8'h00);
    $display("test alarm done");
  endtask : t_alarm

  task automatic t_modes;
    wr(IDX_ALARM_MINUTE, 8'h80);
    wr(IDX_ALARM_HOUR, 8'h80);
    wr(IDX_ALARM_WEEK_OR_DAY, 8'h41);
    adv(8'h11, 8'h02, 7'h40, 8'h05, 8'h08, 1'b0);
    adv(8'h11, 8'h02, 7'h08, 8'h05, 8'h00, 1'b0);
    wr(IDX_EXTENSION_CONTROL, 8'h08);
    wr(IDX_ALARM_WEEK_OR_DAY, 8'h15);
    adv(8'h11, 8'h02, 7'h08, 8'h15, 8'h08, 1'b0);
    adv(8'h11, 8'h02, 7'h01, 8'h16, 8'h00, 1'b0);
    wr(IDX_ALARM_WEEK_OR_DAY, 8'h80);
    adv(8'h42, 8'h13, 7'h02, 8'h09, 8'h08, 1'b0);
    wr(IDX_INTERRUPT_CONTROL, 8'h02);
    adv(8'h43, 8'h13, 7'h02, 8'h09, 8'h00, 1'b0);
    wr(IDX_INTERRUPT_CONTROL, 8'h00);
    $display("test modes done");
  endtask : t_modes

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  initial begin
    tk = 5'h00;
    adv_p = 1'b0;
    cal_m = 8'h00;
    cal_h = 8'h00;
    cal_w = 7'h01;
    cal_d = 8'h01;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_count;
    t_restart;
    t_alarm;
    t_modes;
    test_done;
  end

  // Whole run needs under a thousand cycles; this leaves ample margin
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    test_done;
  end
endmodule : rtc_countdown_and_alarm_irq_bench
